// ---- src/ihf_pkg.sv ----
// ihf_pkg: constants shared by the host front end and its spi link
// assumes a 200 MHz core clock and a host that is always bus master
package ihf_pkg;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CORE_CLK_HZ = 200_000_000;
	localparam int FAST_RATE_HZ = 8000;
	localparam int SLOW_RATE_HZ = 1000;
	localparam int FAST_CYCLES = CORE_CLK_HZ / FAST_RATE_HZ;
	localparam int SLOW_CYCLES = CORE_CLK_HZ / SLOW_RATE_HZ;

	// --------------------------------------------------------------
	// register map seen over either serial port
	// --------------------------------------------------------------
	localparam logic [5:0] I2C_ADDR_HIGH = 6'h34;
	localparam int IMG_BYTES = 28;
	localparam logic [6:0] REG_RATE_DIV = 7'h00;
	localparam logic [6:0] REG_FILTER = 7'h01;
	localparam logic [6:0] REG_GYRO_CFG = 7'h02;
	localparam logic [6:0] REG_ACCEL_CFG = 7'h03;
	localparam logic [6:0] REG_INT_PIN = 7'h04;
	localparam logic [6:0] REG_PWR = 7'h05;
	localparam logic [6:0] REG_STATUS = 7'h06;
	localparam logic [6:0] REG_DATA_BASE = 7'h10;
	localparam logic [6:0] DATA_BYTES = 7'h0C;

	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int FS_LSB = 3;
	localparam int INT_OD_BIT = 0;
	localparam int INT_LOW_BIT = 1;
	localparam int PWR_RESET_BIT = 7;
	localparam int PWR_SLEEP_BIT = 6;
	localparam int STAT_FRAME_SYNC_INPUT_BIT = 0;
	localparam int STAT_I2C_BIT = 1;
	localparam int SPI_READ_BIT = 7;
	localparam logic [7:0] RATE_DIV_RST = 8'h00;
	localparam logic [2:0] FILTER_RST = 3'h0;
	localparam logic [1:0] FS_RST = 2'h0;
	localparam logic [1:0] INT_PIN_RST = 2'h0;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_ACKA = 3'b011,
		I2C_RECV = 3'b010,
		I2C_ACKW = 3'b110,
		I2C_SEND = 3'b111,
		I2C_ACKR = 3'b101
	} ihf_i2c_state_type;
endpackage

// ---- src/ihf_spi_link.sv ----
// ihf_spi_link: spi target logic on the host's serial clock
// assumes the core freezes imageIn while chip select is low
`timescale 1ns/1ps
module ihf_spi_link
	import ihf_pkg::*;
(
	input wire logic spiClk,
	input wire logic csPin,
	input wire logic rst,
	input wire logic mosi,
	input wire logic [IMG_BYTES-1:0][7:0] imageIn,
	output logic misoOut,
	output logic wrToggle,
	output logic [6:0] wrAddr,
	output logic [7:0] wrData
);
	logic [2:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic [6:0] addr_reg;
	logic haveCmd_reg;
	logic readMode_reg;
	logic [7:0] tx_reg;

	wire [7:0] inByte = {shift_reg[6:0], mosi};
	wire byteDone = bitCnt_reg == 3'h7;
	wire inMap = addr_reg < 7'(IMG_BYTES);
	wire [7:0] rdByte = inMap ? imageIn[addr_reg[4:0]] : 8'h00;
	wire loadByte = bitCnt_reg == 3'h0 && haveCmd_reg && readMode_reg;

	// ---------------------------------------------------------------
	// receive: chip select high ends the frame without a clock edge
	// ---------------------------------------------------------------
	always_ff @(posedge spiClk or posedge csPin)
	begin
		if (csPin)
		begin
			bitCnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			addr_reg <= 7'h00;
			haveCmd_reg <= 1'b0;
			readMode_reg <= 1'b0;
		end
		else
		begin
			shift_reg <= inByte;
			bitCnt_reg <= bitCnt_reg + 3'h1;
			if (byteDone && !haveCmd_reg)
			begin
				haveCmd_reg <= 1'b1;
				readMode_reg <= inByte[SPI_READ_BIT];
				addr_reg <= inByte[6:0];
			end
			else if (byteDone)
				addr_reg <= addr_reg + 7'h01;
		end
	end

	// ---------------------------------------------------------------
	// write hand-off: not cleared by chip select, the core may still
	// be sampling the word after the frame has closed
	// ---------------------------------------------------------------
	always_ff @(posedge spiClk or posedge rst)
	begin
		if (rst)
		begin
			wrToggle <= 1'b0;
			wrAddr <= 7'h00;
			wrData <= 8'h00;
		end
		else if (byteDone && haveCmd_reg && !readMode_reg)
		begin
			wrToggle <= ~wrToggle;
			wrAddr <= addr_reg;
			wrData <= inByte;
		end
	end

	// ---------------------------------------------------------------
	// transmit on the falling edge, modes 0 and 3
	// ---------------------------------------------------------------
	always_ff @(negedge spiClk or posedge csPin)
	begin
		if (csPin)
		begin
			tx_reg <= 8'h00;
			misoOut <= 1'b0;
		end
		else if (loadByte)
		begin
			tx_reg <= {rdByte[6:0], 1'b0};
			misoOut <= rdByte[7];
		end
		else
		begin
			tx_reg <= {tx_reg[6:0], 1'b0};
			misoOut <= tx_reg[7];
		end
	end
endmodule

// ---- src/ihf_front_end.sv ----
// ihf_front_end: host port, configuration and sample pacing
// assumes sensor samples and intRequest come from core_clk logic
`timescale 1ns/1ps
module ihf_front_end
	import ihf_pkg::*;
#(
	parameter int FAST_TICK = FAST_CYCLES,
	parameter int SLOW_TICK = SLOW_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic chipSelectPin,
	input wire logic spiSerialClockPin,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addressLsbStrap,
	output logic sdoOut,
	output logic sdoOe,
	input wire logic frameSyncInput,
	input wire logic intRequest,
	output logic intPinOut,
	output logic intPinOe,
	input wire logic [2:0][15:0] gyroSampleIn,
	input wire logic [2:0][15:0] accelSampleIn,
	output logic [1:0] gyroFullScale,
	output logic [1:0] accelFullScale,
	output logic [2:0] filterSelect,
	output logic [7:0] rateDivider,
	output logic sleepMode,
	output logic softResetPulse,
	output logic sampleTick
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [1:0] csSync_reg, sclSync_reg, sdaSync_reg, strapSync_reg;
	logic [1:0] fsyncSync_reg, wrTglSync_reg;
	logic sclPrev_reg, sdaPrev_reg, fsyncPrev_reg, wrTglPrev_reg;
	ihf_i2c_state_type i2cState_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] rx_reg, tx_reg;
	logic [6:0] ptr_reg, i2cWrAddr_reg;
	logic [7:0] i2cWrData_reg;
	logic i2cWr_reg, readMode_reg, firstByte_reg, masterNack_reg;
	logic [1:0] intCfg_reg;
	logic [17:0] baseCnt_reg;
	logic [7:0] divCnt_reg;
	logic [2:0][15:0] gyroFilt_reg, accel_reg;
	logic fsyncFlag_reg, fsyncStatus_reg;
	logic [IMG_BYTES-1:0][7:0] image_reg;
	logic spiToggle;
	logic [6:0] spiWrAddr;
	logic [7:0] spiWrData;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire i2cMode = csSync_reg[1];
	wire sclS = sclSync_reg[1];
	wire sdaS = sdaSync_reg[1];
	wire fsyncS = fsyncSync_reg[1];
	wire sclRise = sclS && !sclPrev_reg;
	wire sclFall = !sclS && sclPrev_reg;
	wire busHigh = sclS && sclPrev_reg;
	wire startCond = busHigh && sdaPrev_reg && !sdaS;
	wire stopCond = busHigh && !sdaPrev_reg && sdaS;
	wire [6:0] myAddr = {I2C_ADDR_HIGH, strapSync_reg[1]};
	wire addrHit = rx_reg[7:1] == myAddr;
	wire byteIn = sclFall && bitCnt_reg == 4'h8;
	wire [7:0] txByte = ptr_reg < 7'(IMG_BYTES) ?
		image_reg[ptr_reg[4:0]] : 8'h00;
	wire spiWrite = wrTglSync_reg[1] ^ wrTglPrev_reg;
	wire wrEn = i2cWr_reg || spiWrite;
	wire [6:0] wrAddr = i2cWr_reg ? i2cWrAddr_reg : spiWrAddr;
	wire [7:0] wrData = i2cWr_reg ? i2cWrData_reg : spiWrData;
	wire fastBase = filterSelect == 3'h0 || filterSelect == 3'h7;
	wire [17:0] baseLimit = fastBase ?
		18'(FAST_TICK - 1) : 18'(SLOW_TICK - 1);
	wire baseTick = baseCnt_reg >= baseLimit;
	wire sampleNow = baseTick && divCnt_reg >= rateDivider;
	wire fsyncRise = fsyncS && !fsyncPrev_reg;
	wire intLevel = intRequest ^ intCfg_reg[INT_LOW_BIT];

	// first-order low-pass; the step never overshoots, so the 16-bit
	// wrap of the sum is exact
	function automatic logic [15:0] lowPass(input logic [15:0] acc,
		input logic [15:0] x, input logic [2:0] k);
		logic signed [16:0] d;
		logic signed [16:0] s;
		d = $signed({x[15], x}) - $signed({acc[15], acc});
		s = d >>> k;
		lowPass = (k == 3'h0 || k == 3'h7) ? x : acc + s[15:0];
	endfunction

	function automatic logic [7:0] regByte(input logic [6:0] a);
		logic [6:0] k;
		logic [15:0] w;
		k = a - REG_DATA_BASE;
		w = k[3:1] < 3'h3 ? accel_reg[k[2:1]] :
			gyroFilt_reg[2'(k[3:1] - 3'h3)];
		regByte = 8'h00;
		if (a >= REG_DATA_BASE && k < DATA_BYTES)
			regByte = k[0] ? w[7:0] : w[15:8];
		else if (a == REG_RATE_DIV)
			regByte = rateDivider;
		else if (a == REG_FILTER)
			regByte = {5'h00, filterSelect};
		else if (a == REG_GYRO_CFG)
			regByte = 8'(gyroFullScale) << FS_LSB;
		else if (a == REG_ACCEL_CFG)
			regByte = 8'(accelFullScale) << FS_LSB;
		else if (a == REG_INT_PIN)
			regByte = {6'h00, intCfg_reg};
		else if (a == REG_PWR)
			regByte = 8'(sleepMode) << PWR_SLEEP_BIT;
		else if (a == REG_STATUS)
			regByte = 8'(i2cMode) << STAT_I2C_BIT |
				8'(fsyncStatus_reg) << STAT_FRAME_SYNC_INPUT_BIT;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			csSync_reg <= 2'h3;
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			strapSync_reg <= 2'h0;
			fsyncSync_reg <= 2'h0;
			wrTglSync_reg <= 2'h0;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			fsyncPrev_reg <= 1'b0;
			wrTglPrev_reg <= 1'b0;
		end
		else
		begin
			csSync_reg <= {csSync_reg[0], chipSelectPin};
			sclSync_reg <= {sclSync_reg[0], spiSerialClockPin};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			strapSync_reg <= {strapSync_reg[0], addressLsbStrap};
			fsyncSync_reg <= {fsyncSync_reg[0], frameSyncInput};
			wrTglSync_reg <= {wrTglSync_reg[0], spiToggle};
			sclPrev_reg <= sclS;
			sdaPrev_reg <= sdaS;
			fsyncPrev_reg <= fsyncS;
			wrTglPrev_reg <= wrTglSync_reg[1];
		end
	end

	// ---------------------------------------------------------------
	// i2c target, sampled on the core clock
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		i2cWr_reg <= 1'b0;
		if (rst || !i2cMode || stopCond)
		begin
			i2cState_reg <= I2C_IDLE;
			bitCnt_reg <= 4'h0;
			sdaOe <= 1'b0;
			readMode_reg <= 1'b0;
			firstByte_reg <= 1'b0;
			masterNack_reg <= 1'b0;
			rx_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= rst ? 7'h00 : ptr_reg;
			i2cWrAddr_reg <= 7'h00;
			i2cWrData_reg <= 8'h00;
		end
		else if (startCond)
		begin
			i2cState_reg <= I2C_ADDR;
			bitCnt_reg <= 4'h0;
			sdaOe <= 1'b0;
		end
		else
		begin
			unique case (i2cState_reg)
			I2C_IDLE:
				bitCnt_reg <= 4'h0;
			I2C_ADDR, I2C_RECV:
				if (sclRise)
				begin
					rx_reg <= {rx_reg[6:0], sdaS};
					bitCnt_reg <= bitCnt_reg + 4'h1;
				end
				else if (byteIn && i2cState_reg == I2C_ADDR)
				begin
					bitCnt_reg <= 4'h0;
					sdaOe <= addrHit;
					readMode_reg <= rx_reg[0];
					firstByte_reg <= 1'b1;
					i2cState_reg <= addrHit ? I2C_ACKA : I2C_IDLE;
				end
				else if (byteIn)
				begin
					bitCnt_reg <= 4'h0;
					sdaOe <= 1'b1;
					firstByte_reg <= 1'b0;
					i2cState_reg <= I2C_ACKW;
					ptr_reg <= firstByte_reg ? rx_reg[6:0] :
						ptr_reg + 7'h01;
					i2cWr_reg <= !firstByte_reg;
					i2cWrAddr_reg <= ptr_reg;
					i2cWrData_reg <= rx_reg;
				end
			I2C_ACKW:
				if (sclFall)
				begin
					sdaOe <= 1'b0;
					i2cState_reg <= I2C_RECV;
				end
			I2C_SEND:
				if (sclFall && bitCnt_reg == 4'h8)
				begin
					sdaOe <= 1'b0;
					i2cState_reg <= I2C_ACKR;
				end
				else if (sclFall)
				begin
					sdaOe <= !tx_reg[7];
					tx_reg <= {tx_reg[6:0], 1'b0};
					bitCnt_reg <= bitCnt_reg + 4'h1;
				end
			I2C_ACKA, I2C_ACKR:
				if (sclRise)
					masterNack_reg <= sdaS;
				else if (sclFall && i2cState_reg == I2C_ACKA &&
					!readMode_reg)
				begin
					sdaOe <= 1'b0;
					i2cState_reg <= I2C_RECV;
				end
				else if (sclFall && i2cState_reg == I2C_ACKR &&
					masterNack_reg)
				begin
					sdaOe <= 1'b0;
					i2cState_reg <= I2C_IDLE;
				end
				else if (sclFall)
				begin
					tx_reg <= {txByte[6:0], 1'b0};
					sdaOe <= !txByte[7];
					bitCnt_reg <= 4'h1;
					ptr_reg <= ptr_reg + 7'h01;
					i2cState_reg <= I2C_SEND;
				end
			default:
				i2cState_reg <= I2C_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		softResetPulse <= 1'b0;
		if (rst || softResetPulse)
		begin
			rateDivider <= RATE_DIV_RST;
			filterSelect <= FILTER_RST;
			gyroFullScale <= FS_RST;
			accelFullScale <= FS_RST;
			intCfg_reg <= INT_PIN_RST;
			sleepMode <= 1'b0;
		end
		else if (wrEn)
		begin
			if (wrAddr == REG_RATE_DIV)
				rateDivider <= wrData;
			if (wrAddr == REG_FILTER)
				filterSelect <= wrData[2:0];
			if (wrAddr == REG_GYRO_CFG)
				gyroFullScale <= wrData[FS_LSB+:2];
			if (wrAddr == REG_ACCEL_CFG)
				accelFullScale <= wrData[FS_LSB+:2];
			if (wrAddr == REG_INT_PIN)
				intCfg_reg <= wrData[1:0];
			if (wrAddr == REG_PWR)
			begin
				softResetPulse <= wrData[PWR_RESET_BIT];
				sleepMode <= wrData[PWR_SLEEP_BIT];
			end
		end
	end

	// ---------------------------------------------------------------
	// sample pacing and capture
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst || sleepMode)
		begin
			baseCnt_reg <= 18'h00000;
			divCnt_reg <= 8'h00;
			sampleTick <= 1'b0;
		end
		else
		begin
			baseCnt_reg <= baseTick ? 18'h00000 : baseCnt_reg + 18'h00001;
			divCnt_reg <= !baseTick ? divCnt_reg :
				sampleNow ? 8'h00 : divCnt_reg + 8'h01;
			sampleTick <= sampleNow;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			gyroFilt_reg <= '0;
			accel_reg <= '0;
			fsyncFlag_reg <= 1'b0;
			fsyncStatus_reg <= 1'b0;
		end
		else if (sampleNow && !sleepMode)
		begin
			// a frame sync edge in the capture cycle is kept
			fsyncStatus_reg <= fsyncFlag_reg || fsyncRise;
			fsyncFlag_reg <= fsyncRise;
			accel_reg <= accelSampleIn;
			for (int i = 0; i < 3; i++)
				gyroFilt_reg[i] <= lowPass(gyroFilt_reg[i],
					gyroSampleIn[i], filterSelect);
		end
		else if (fsyncRise)
			fsyncFlag_reg <= 1'b1;
	end

	// ---------------------------------------------------------------
	// read image, frozen while spi owns the port so the link clock
	// domain sees only settled bytes
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
			image_reg <= '0;
		else if (i2cMode)
			for (int i = 0; i < IMG_BYTES; i++)
				image_reg[i] <= regByte(7'(i));
	end

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sdaOut <= 1'b0;
			sdoOe <= 1'b0;
			intPinOut <= 1'b0;
			intPinOe <= 1'b0;
		end
		else
		begin
			sdaOut <= 1'b0;
			sdoOe <= !i2cMode;
			// open-drain can only pull low, so it drives the low level
			intPinOut <= intCfg_reg[INT_OD_BIT] ? 1'b0 : intLevel;
			intPinOe <= intCfg_reg[INT_OD_BIT] ? !intLevel : 1'b1;
		end
	end

	ihf_spi_link spiLink (
		.spiClk(spiSerialClockPin),
		.csPin(chipSelectPin),
		.rst(rst),
		.mosi(sdaIn),
		.imageIn(image_reg),
		.misoOut(sdoOut),
		.wrToggle(spiToggle),
		.wrAddr(spiWrAddr),
		.wrData(spiWrData)
	);
endmodule

// ---- bench/ihf_chk.sv ----
// ihf_chk: port assertions for ihf_front_end
// assumes it is bound into every ihf_front_end
`timescale 1ns/1ps
module ihf_chk
	import ihf_pkg::*;
#(
	parameter int FAST_TICK = FAST_CYCLES,
	parameter int SLOW_TICK = SLOW_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic chipSelectPin,
	input wire logic sdaOe,
	input wire logic sdoOe,
	input wire logic intPinOut,
	input wire logic intPinOe,
	input wire logic [1:0] gyroFullScale,
	input wire logic sleepMode,
	input wire logic softResetPulse,
	input wire logic sampleTick
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// cycles since last tick; saturates so it never wraps
	int gap_reg;
	always_ff @(posedge core_clk)
	begin
		if (rst)
			gap_reg <= FAST_TICK;
		else if (sampleTick)
			gap_reg <= 1;
		else if (gap_reg < FAST_TICK)
			gap_reg <= gap_reg + 1;
	end
	a_rst_quiet:
	assert property ($fell(rst) |-> !sdaOe && !sdoOe && !intPinOe
		&& !softResetPulse && !sampleTick)
		else $error("output active at reset release");
	a_soft_defaults:
	assert property (softResetPulse |=> !softResetPulse && !sleepMode
		&& gyroFullScale == 2'h0)
		else $error("config kept after soft reset");
	a_tick_gap:
	assert property (sampleTick |-> gap_reg >= FAST_TICK)
		else $error("sample ticks too close");
	a_sleep_still:
	assert property (sleepMode [*2] |-> !sampleTick)
		else $error("tick while asleep");
	a_int_od_low:
	assert property (intPinOut |-> intPinOe)
		else $error("int high while undriven");
	a_sdo_quiet:
	assert property (chipSelectPin [*5] |-> !sdoOe)
		else $error("strap pin driven in i2c mode");
	a_sdo_drive:
	assert property (!chipSelectPin [*5] |-> sdoOe)
		else $error("data out idle in spi frame");
	a_sda_spi:
	assert property (!chipSelectPin [*5] |-> !sdaOe)
		else $error("sda pulled in spi frame");
endmodule

bind ihf_front_end ihf_chk #(.FAST_TICK(FAST_TICK), .SLOW_TICK(SLOW_TICK))
	u_chk (.core_clk(core_clk), .rst(rst), .chipSelectPin(chipSelectPin),
	.sdaOe(sdaOe), .sdoOe(sdoOe), .intPinOut(intPinOut),
	.intPinOe(intPinOe), .gyroFullScale(gyroFullScale),
	.sleepMode(sleepMode), .softResetPulse(softResetPulse),
	.sampleTick(sampleTick));

// ---- bench/ihf_host_model.sv ----
// ihf_host_model: system processor as spi mode 3 or i2c master
// assumes the bench resolves sda with a pull-up and an undriven sdo to the strap level
`timescale 1ns/1ps
module ihf_host_model
(
	output logic csPin,
	output logic sckPin,
	output logic sdaDrive,
	input wire logic sdaLine,
	input wire logic sdoLine
);
	// 8 MHz spi clock, phase unrelated to the core clock
	localparam realtime HALF = 62.5;
	localparam realtime QTR = 50.0;
	logic [7:0] dataQ [16] = '{default: 8'h00};
	// clock idles high, so the clock is high whenever cs falls or rises
	initial
	begin
		csPin = 1'b1;
		sckPin = 1'b1;
		sdaDrive = 1'b1;
	end
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sckPin = 1'b0;
			sdaDrive = tx[i];
			#HALF sckPin = 1'b1;
			rx[i] = sdoLine;
			#HALF;
		end
	endtask
	task automatic spi_frame(input logic [7:0] cmd, input int n);
		logic [7:0] rx;
		csPin = 1'b0;
		#HALF spi_byte(cmd, rx);
		for (int k = 0; k < n; k++)
			spi_byte(dataQ[k], dataQ[k]);
		sdaDrive = 1'b1;
		csPin = 1'b1;
		#HALF;
	endtask
	task automatic i2c_byte(input logic [7:0] tx, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sdaDrive = tx[i];
			#QTR sckPin = 1'b1;
			#QTR sckPin = 1'b0;
			#QTR;
		end
		sdaDrive = 1'b1;
		#QTR sckPin = 1'b1;
		ack = !sdaLine;
		#QTR sckPin = 1'b0;
		#QTR;
	endtask
	task automatic i2c_write(input logic [6:0] adr, input logic [7:0] ra,
		input logic [7:0] val, output logic ack);
		logic a1;
		logic a2;
		sdaDrive = 1'b0;
		#QTR sckPin = 1'b0;
		#QTR i2c_byte({adr, 1'b0}, ack);
		i2c_byte(ra, a1);
		i2c_byte(val, a2);
		ack = ack && a1 && a2;
		sdaDrive = 1'b0;
		#QTR sckPin = 1'b1;
		#QTR sdaDrive = 1'b1;
		#QTR;
	endtask
endmodule

// ---- bench/ihf_front_end_tb_top.sv ----
// ihf_front_end_tb_top: self-checking bench for ihf_front_end
// assumes ihf_host_model as host and ihf_chk bound in
`timescale 1ns/1ps
module ihf_front_end_tb_top
	import ihf_pkg::*;
;
	// short tick periods keep the run brief
	localparam int FT = 20;
	localparam int ST = 40;
	localparam int LIMIT = 400;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic strap = 1'b1;
	logic intReq = 1'b0;
	logic [2:0][15:0] gyroIn = '0;
	logic [2:0][15:0] accelIn = '0;
	logic [7:0] q [16];
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int pulses = 0;
	wire csPin, sckPin, sdaDrive, sdaOut, sdaOe, sdoOut, sdoOe;
	wire intOut, intOe, sleep, softRst, sampleTk;
	wire [1:0] gyroFs, accelFs;
	wire [2:0] filt;
	wire [7:0] rateDiv;
	wire sdaLine = sdaDrive && !(sdaOe && !sdaOut);
	wire sdoLine = sdoOe ? sdoOut : strap;
	ihf_host_model u_host (.csPin(csPin), .sckPin(sckPin),
		.sdaDrive(sdaDrive), .sdaLine(sdaLine), .sdoLine(sdoLine));
	ihf_front_end #(.FAST_TICK(FT), .SLOW_TICK(ST)) u_dut (
		.core_clk(core_clk), .rst(rst), .chipSelectPin(csPin),
		.spiSerialClockPin(sckPin), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .addressLsbStrap(sdoLine), .sdoOut(sdoOut),
		.sdoOe(sdoOe), .frameSyncInput(1'b0),
		.intRequest(intReq), .intPinOut(intOut), .intPinOe(intOe),
		.gyroSampleIn(gyroIn), .accelSampleIn(accelIn),
		.gyroFullScale(gyroFs), .accelFullScale(accelFs),
		.filterSelect(filt), .rateDivider(rateDiv), .sleepMode(sleep),
		.softResetPulse(softRst), .sampleTick(sampleTk));
	always #2.5 core_clk = ~core_clk;
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic give_verdict();
		$display("checks %0d bad %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (softRst === 1'b1)
			pulses++;
		if (cycles == 60000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] want);
		comparisons++;
		if (seen !== want)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_tick(output int n);
		n = 0;
		do
		begin
			tick(1);
			n++;
		end while (sampleTk !== 1'b1 && n < LIMIT);
	endtask
	task automatic spi_wr(input logic [6:0] a, input logic [7:0] d);
		u_host.dataQ[0] = d;
		u_host.spi_frame({1'b0, a}, 1);
		tick(8);
	endtask
	task automatic spi_rd(input logic [6:0] a, input int n);
		u_host.spi_frame({1'b1, a}, n);
		tick(1);
		q = u_host.dataQ;
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_ranges();
		for (int k = 0; k < 4; k++)
		begin
			u_host.dataQ[0] = 8'(k << FS_LSB);
			u_host.dataQ[1] = 8'((3 - k) << FS_LSB);
			u_host.spi_frame({1'b0, REG_GYRO_CFG}, 2);
			tick(8);
			check("gyro fs", gyroFs, 16'(k));
			check("accel fs", accelFs, 16'(3 - k));
			spi_rd(REG_GYRO_CFG, 2);
			check("fs read", {q[0], q[1]},
				{8'(k << 3), 8'((3 - k) << 3)});
		end
	endtask
	task automatic t_samples();
		int n;
		logic [15:0] w;
		accelIn = {16'h4000, 16'h0000, 16'h0000};
		gyroIn = {16'h8001, 16'h7FFE, 16'h1234};
		wait_tick(n);
		wait_tick(n);
		tick(8);
		spi_rd(REG_DATA_BASE, 13);
		for (int i = 0; i < 6; i++)
		begin
			w = (i < 3) ? accelIn[i] : gyroIn[i - 3];
			check("sample", {q[2 * i], q[2 * i + 1]}, w);
		end
		check("past end", q[12], 16'h0000);
	endtask
	task automatic rate_case(input logic [2:0] f, input int base);
		int n;
		spi_wr(REG_FILTER, {5'h00, f});
		check("filter", filt, f);
		wait_tick(n);
		wait_tick(n);
		check("tick gap", 16'(n), 16'(3 * base));
	endtask
	task automatic t_int();
		logic lvl;
		for (int m = 0; m < 8; m++)
		begin
			spi_wr(REG_INT_PIN, 8'(m >> 1));
			intReq = m[0];
			lvl = m[0] ^ m[2];
			tick(4);
			check("int pin", {intOe, intOut},
				m[1] ? {!lvl, 1'b0} : {1'b1, lvl});
		end
	endtask
	task automatic t_sleep();
		int n;
		spi_wr(REG_GYRO_CFG, 8'h18);
		spi_wr(REG_PWR, 8'h40);
		check("sleep", sleep, 1'b1);
		wait_tick(n);
		check("asleep gap", 16'(n), 16'(LIMIT));
		pulses = 0;
		spi_wr(REG_PWR, 8'h80);
		check("pulses", 16'(pulses), 16'h0001);
		check("after reset", {gyroFs, sleep}, 16'h0000);
		wait_tick(n);
		check("awake", 16'(n < LIMIT), 16'h0001);
	endtask
	task automatic t_i2c();
		logic ack;
		for (int s = 0; s < 2; s++)
		begin
			strap = s[0];
			tick(4);
			u_host.i2c_write({I2C_ADDR_HIGH, !s[0]}, 8'(REG_GYRO_CFG),
				8'h18, ack);
			check("foreign ack", ack, 1'b0);
			u_host.i2c_write({I2C_ADDR_HIGH, s[0]}, 8'(REG_GYRO_CFG),
				8'(8 * s + 8), ack);
			tick(4);
			check("own ack", ack, 1'b1);
			check("i2c fs", gyroFs, 16'(s + 1));
			check("strap in", sdoOe, 1'b0);
		end
	endtask
	initial
	begin
		tick(16);
		rst = 1'b0;
		tick(6);
		check("idle cfg", {gyroFs, accelFs, filt, sleep, rateDiv},
			16'h0000);
		check("idle oe", {sdaOe, sdoOe}, 16'h0000);
		t_ranges();
		t_samples();
		spi_wr(REG_RATE_DIV, 8'h02);
		check("divider", rateDiv, 8'h02);
		rate_case(3'h1, ST);
		rate_case(3'h7, FT);
		rate_case(3'h0, FT);
		t_int();
		t_sleep();
		t_i2c();
		give_verdict();
	end
endmodule
